// ### host_cmd_ctrl.v
// Host-side sequencer for generic commands and key table commands
`timescale 1ns/1ns
// Contract
// - Slot mask command type 3, bitmap pointer
// - Stop: write time, then type 4 active
// - Remote wake attribute set when polling wanted
// - Wake poll type 5, enabled bit on/off
// - Install: identifier, key, then command with set
// - Never issue index at or above capacity
// - Erase: erase bit set, set bit zero
// - Never erase an entry without valid key
// - Handshake clears secure flag, idles queue heads
// - Pairwise install, then index and secure flag
// - Group key installed before slot mask write
// - Never erase group key while broadcasting
// - No new command while active bit is one
`include "host_cmd_defs.vh"

module host_cmd_ctrl #(
  parameter MAX_KEYS = 32
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire [7:0]  sw_addr,
  input  wire [31:0] sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  output reg  [31:0] sw_rdata,
  output reg  [7:0]  dev_addr,
  output reg  [31:0] dev_wdata,
  output reg         dev_wr,
  output reg         dev_rd,
  input  wire [31:0] dev_rdata,
  output reg         queue_idle_req
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_PRE   = 3'h1;
  localparam S_PREW  = 3'h2;
  localparam S_WR    = 3'h3;
  localparam S_POLL  = 3'h4;
  localparam S_POLLW = 3'h5;

  reg [2:0]  state_r;
  reg [2:0]  step_r;
  reg [2:0]  op_r;
  reg [31:0] gen_cmd_r;
  reg [31:0] gen_param_r;
  reg [31:0] gen_addr_r;
  reg [31:0] key_id_r;
  reg [31:0] key_val_r [0:3];
  reg [31:0] key_cmd_r;
  reg        done_r;
  reg        err_r;
  reg        refused_r;
  reg        slots_set_r;
  reg        wake_poll_r;
  reg        secure_r;
  reg [7:0]  info_idx_r;

  wire [MAX_KEYS-1:0] kvalid;
  wire [MAX_KEYS-1:0] kgroup;
  wire [7:0]  key_idx   = key_cmd_r[`KEY_IDX_MSB:0];
  wire        key_grp   = key_cmd_r[`KEY_GROUP_BIT];
  wire [3:0]  gen_type  = gen_cmd_r[`GEN_TYPE_MSB:0];
  wire        group_ok  = |(kvalid & kgroup);
  wire        idx_in    = ({24'h0, key_idx} < MAX_KEYS);
  wire        busy      = (state_r != S_IDLE);
  wire        start     = sw_wr && (sw_addr == `REG_CTRL) && !busy;
  wire [2:0]  start_op  = sw_wdata[2:0];
  wire        cfg_wr    = sw_wr && !busy;
  wire [31:0] pre_word  = dev_rdata;
  wire [7:0]  cap       = pre_word[`CAP_MSB:`CAP_LSB];

  // ----------------------------------------
  // Start-time checks
  // ----------------------------------------
  reg refuse_now;
  always @*
  begin
    refuse_now = 1'b0;
    case (start_op)
      `OP_GENERIC:
        refuse_now = (sw_wdata[3:0] == 4'h0) ? 1'b0 :
                     ((gen_type == `GEN_TYPE_SLOTS) && !group_ok);
      `OP_KEY_SET:
        refuse_now = !idx_in;
      `OP_KEY_ERASE:
      begin
        refuse_now = !idx_in || !kvalid[key_idx[4:0] % MAX_KEYS];
        if (idx_in && kgroup[key_idx[4:0] % MAX_KEYS] && slots_set_r)
          refuse_now = 1'b1;
      end
      default:
        refuse_now = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Write list per operation
  // ----------------------------------------
  reg [7:0]  w_addr;
  reg [31:0] w_data;
  reg        w_last;
  always @*
  begin
    w_addr = `DEV_GEN_STS;
    w_data = `RESET_WORD;
    w_last = 1'b0;
    if (op_r == `OP_GENERIC)
    begin
      case (step_r)
        3'h0:
        begin
          w_addr = `DEV_GEN_PARAM;
          w_data = gen_param_r;
        end
        3'h1:
        begin
          w_addr = `DEV_GEN_ADDR;
          w_data = gen_addr_r;
        end
        default:
        begin
          w_addr = `DEV_GEN_STS;
          w_data = {1'b1, 1'b0, gen_cmd_r[29:0]};
          w_last = 1'b1;
        end
      endcase
    end
    else if (op_r == `OP_KEY_SET)
    begin
      if (step_r == 3'h0)
      begin
        w_addr = `DEV_KEY_ID;
        w_data = {8'h00, key_id_r[23:0]};
      end
      else if (step_r < 3'h5)
      begin
        w_addr = `DEV_KEY_VAL0 + {3'h0, step_r - 3'h1, 2'b00};
        w_data = key_val_r[step_r[1:0] - 2'b01];
      end
      else
      begin
        w_addr = `DEV_KEY_CMD;
        w_data = {1'b1, 1'b0, 21'h0, key_grp, key_idx};
        w_last = 1'b1;
      end
    end
    else
    begin
      w_addr = `DEV_KEY_CMD;
      w_data = {1'b0, 1'b1, 22'h0, key_idx};
      w_last = 1'b1;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  integer k;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      gen_cmd_r   <= `RESET_WORD;
      gen_param_r <= `RESET_WORD;
      gen_addr_r  <= `RESET_WORD;
      key_id_r    <= `RESET_WORD;
      key_cmd_r   <= `RESET_WORD;
      for (k = 0; k < 4; k = k + 1)
        key_val_r[k] <= `RESET_WORD;
    end
    else if (cfg_wr)
    begin
      // Held stable while busy so the device sees one consistent set
      case (sw_addr)
        `REG_GEN_CMD:   gen_cmd_r   <= sw_wdata;
        // wake attribute travels in the parameter word
        `REG_GEN_PARAM: gen_param_r <= sw_wdata;
        `REG_GEN_ADDR:  gen_addr_r  <= sw_wdata;
        `REG_KEY_ID:    key_id_r    <= sw_wdata;
        `REG_KEY_CMD:   key_cmd_r   <= sw_wdata;
        8'h14:          key_val_r[0] <= sw_wdata;
        8'h18:          key_val_r[1] <= sw_wdata;
        8'h1C:          key_val_r[2] <= sw_wdata;
        8'h20:          key_val_r[3] <= sw_wdata;
        default:        key_id_r    <= key_id_r;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  wire fin      = (state_r == S_POLLW) && !(op_r == `OP_GENERIC ? dev_rdata[`GEN_ACTIVE_BIT] :
                  op_r == `OP_KEY_SET ? dev_rdata[`KEY_SET_BIT] : dev_rdata[`KEY_ERASE_BIT]);
  wire cap_bad  = (state_r == S_PREW) && (op_r != `OP_GENERIC) && (key_idx >= cap);
  wire fin_set  = fin && (op_r == `OP_KEY_SET);
  wire fin_ers  = fin && (op_r == `OP_KEY_ERASE);
  wire hs_start = start && (start_op == `OP_HANDSHAKE);
  wire refuse   = (start && refuse_now) || cap_bad;

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      state_r  <= S_IDLE;
      step_r   <= 3'h0;
      op_r     <= 3'h0;
      dev_addr <= 8'h00;
      dev_wdata <= `RESET_WORD;
      dev_wr   <= 1'b0;
      dev_rd   <= 1'b0;
    end
    else
    begin
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          step_r <= 3'h0;
          if (start && !refuse_now && start_op >= `OP_GENERIC && start_op <= `OP_KEY_ERASE)
          begin
            op_r    <= start_op;
            state_r <= S_PRE;
          end
        end
        S_PRE:
        begin
          dev_rd   <= 1'b1;
          dev_addr <= (op_r == `OP_GENERIC) ? `DEV_GEN_STS : `DEV_STRUCT;
          state_r  <= S_PREW;
        end
        S_PREW:
        begin
          // Wait state: read data stands in this cycle
          if (op_r == `OP_GENERIC)
          begin
            state_r <= dev_rdata[`GEN_ACTIVE_BIT] ? S_PRE : S_WR;
          end
          else
          begin
            state_r <= cap_bad ? S_IDLE : S_WR;
          end
        end
        S_WR:
        begin
          dev_wr    <= 1'b1;
          dev_addr  <= w_addr;
          dev_wdata <= w_data;
          step_r    <= step_r + 3'h1;
          if (w_last)
            state_r <= S_POLL;
        end
        S_POLL:
        begin
          dev_rd   <= 1'b1;
          dev_addr <= (op_r == `OP_GENERIC) ? `DEV_GEN_STS : `DEV_KEY_CMD;
          state_r  <= S_POLLW;
        end
        S_POLLW:
          // Device never waits us; poll until its bit drops
          state_r <= fin ? S_IDLE : S_POLL;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Key table shadow, one entry per index
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < MAX_KEYS; i = i + 1)
    begin : entry
      localparam [7:0] ENTRY = i;
      reg valid_r;
      reg group_r;
      always @(posedge clock)
      begin
        if (!rstn)
        begin
          valid_r <= 1'b0;
          group_r <= 1'b0;
        end
        else if (fin_set && key_idx == ENTRY)
        begin
          valid_r <= 1'b1;
          group_r <= key_grp;
        end
        else if (fin_ers && key_idx == ENTRY)
          valid_r <= 1'b0;
      end
      assign kvalid[i] = valid_r;
      assign kgroup[i] = group_r;
    end
  endgenerate

  // ----------------------------------------
  // Status and device information
  // ----------------------------------------
  wire clr_st = sw_wr && (sw_addr == `REG_STATUS);
  wire fin_gen = fin && (op_r == `OP_GENERIC);
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      done_r      <= 1'b0;
      err_r       <= 1'b0;
      refused_r   <= 1'b0;
      slots_set_r <= 1'b0;
      wake_poll_r <= 1'b0;
      secure_r    <= 1'b0;
      info_idx_r  <= 8'h00;
      queue_idle_req <= 1'b0;
    end
    else
    begin
      // Sticky flags: a hardware set beats a software clear
      done_r    <= (fin || refuse || hs_start) | (done_r & ~(clr_st & sw_wdata[`ST_DONE]));
      refused_r <= refuse | (refused_r & ~(clr_st & sw_wdata[`ST_REFUSED]));
      err_r     <= (fin_gen && dev_rdata[`GEN_ERROR_BIT]) | (err_r & ~(clr_st & sw_wdata[`ST_ERROR]));
      if (fin_gen && gen_type == `GEN_TYPE_SLOTS)
        slots_set_r <= 1'b1;
      if (fin_gen && gen_type == `GEN_TYPE_WAKE)
        wake_poll_r <= gen_param_r[0];
      if (hs_start)
      begin
        secure_r       <= 1'b0;
        queue_idle_req <= 1'b1;
      end
      else if (fin_set && !key_grp)
      begin
        info_idx_r     <= key_idx;
        secure_r       <= 1'b1;
        queue_idle_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software read port, data one cycle later
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
      sw_rdata <= `RESET_WORD;
    else if (sw_rd)
    begin
      case (sw_addr)
        `REG_GEN_CMD:   sw_rdata <= gen_cmd_r;
        `REG_GEN_PARAM: sw_rdata <= gen_param_r;
        `REG_GEN_ADDR:  sw_rdata <= gen_addr_r;
        `REG_KEY_ID:    sw_rdata <= key_id_r;
        `REG_KEY_CMD:   sw_rdata <= key_cmd_r;
        `REG_STATUS:    sw_rdata <= {25'h0, wake_poll_r, slots_set_r, group_ok, refused_r, err_r, done_r, busy};
        `REG_DEV_INFO:  sw_rdata <= {23'h0, secure_r, info_idx_r};
        default:        sw_rdata <= `RESET_WORD;
      endcase
    end
    else
      sw_rdata <= `RESET_WORD;
  end

endmodule

// ### host_cmd_defs.vh
// Constants for the host-side generic command and key table controller
`ifndef HOST_CMD_DEFS_VH
`define HOST_CMD_DEFS_VH
// Device register byte offsets (device map as seen over the device port)
`define DEV_GEN_STS      8'h00
`define DEV_GEN_PARAM    8'h04
`define DEV_GEN_ADDR     8'h08
`define DEV_KEY_CMD      8'h0C
`define DEV_KEY_ID       8'h10
`define DEV_KEY_VAL0     8'h14
`define DEV_STRUCT       8'h24
// Device generic status fields
`define GEN_ACTIVE_BIT   31
`define GEN_ERROR_BIT    30
`define GEN_TYPE_MSB     3
`define GEN_TYPE_SLOTS   4'h3
`define GEN_TYPE_STOP    4'h4
`define GEN_TYPE_WAKE    4'h5
// Device key command fields
`define KEY_SET_BIT      31
`define KEY_ERASE_BIT    30
`define KEY_GROUP_BIT    8
`define KEY_IDX_MSB      7
// Key capacity field in the structural parameters word
`define CAP_LSB          8
`define CAP_MSB          15
// Own register byte offsets (software port)
`define REG_CTRL         8'h00
`define REG_GEN_CMD      8'h04
`define REG_GEN_PARAM    8'h08
`define REG_GEN_ADDR     8'h0C
`define REG_KEY_ID       8'h10
`define REG_KEY_VAL0     8'h14
`define REG_KEY_CMD      8'h24
`define REG_STATUS       8'h28
`define REG_DEV_INFO     8'h2C
// Operation codes written to the control register
`define OP_GENERIC       3'h1
`define OP_KEY_SET       3'h2
`define OP_KEY_ERASE     3'h3
`define OP_HANDSHAKE     3'h4
// Status bit positions
`define ST_BUSY          0
`define ST_DONE          1
`define ST_ERROR         2
`define ST_REFUSED       3
`define ST_GROUP_OK      4
`define ST_SLOTS_SET     5
`define ST_WAKE_POLL     6
// Reset values
`define RESET_WORD       32'h0000_0000
`endif

// ### host_cmd_checker_assertions.sv
// Port checker for the host command sequencer
`timescale 1ns/1ns
`include "host_cmd_defs.vh"
module host_cmd_checker #(
  parameter MAX_KEYS = 32
) (
  input wire        clock,
  input wire        rstn,
  input wire [7:0]  sw_addr,
  input wire [31:0] sw_wdata,
  input wire        sw_wr,
  input wire        sw_rd,
  input wire [31:0] sw_rdata,
  input wire [7:0]  dev_addr,
  input wire [31:0] dev_wdata,
  input wire        dev_wr,
  input wire        dev_rd,
  input wire [31:0] dev_rdata,
  input wire        queue_idle_req
);
  reg       gen_pend_r, grp_seen_r, slots_r;
  reg [7:0] cap_r, grp_idx_r;
  wire      key_cmd_wr = dev_wr && (dev_addr == `DEV_KEY_CMD);
  wire      gen_sts_wr = dev_wr && (dev_addr == `DEV_GEN_STS);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Mirror of device state the sequencer must respect; read data stands in the strobe cycle
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      {gen_pend_r, grp_seen_r, slots_r} <= 3'b000;
      cap_r <= 8'h00;
      grp_idx_r <= 8'h00;
    end
    else
    begin
      if (dev_rd && dev_addr == `DEV_STRUCT)
        cap_r <= dev_rdata[`CAP_MSB:`CAP_LSB];
      if (gen_sts_wr)
        gen_pend_r <= 1'b1;
      else if (dev_rd && dev_addr == `DEV_GEN_STS && !dev_rdata[`GEN_ACTIVE_BIT])
        gen_pend_r <= 1'b0;
      if (key_cmd_wr && dev_wdata[31] && dev_wdata[8])
      begin
        grp_seen_r <= 1'b1;
        grp_idx_r <= dev_wdata[7:0];
      end
      if (gen_sts_wr && dev_wdata[3:0] == `GEN_TYPE_SLOTS)
        slots_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // Ordered write bursts
  // ----------------------------------------
  sequence kw(a);
    dev_wr && dev_addr == a;
  endsequence
  sequence key_load_s;
    kw(`DEV_KEY_ID) ##1 kw(8'h14) ##1 kw(8'h18) ##1 kw(8'h1C) ##1 kw(8'h20);
  endsequence
  sequence gen_load_s;
    kw(`DEV_GEN_PARAM) ##1 kw(`DEV_GEN_ADDR);
  endsequence
  key_order_a: assert property (key_load_s |=> key_cmd_wr && dev_wdata[31] && !dev_wdata[30])
    else $error("key command does not follow key words");
  key_cmd_a: assert property (key_cmd_wr && dev_wdata[31] |-> $past(dev_wr) && $past(dev_addr) == 8'h20)
    else $error("key set issued without key words");
  erase_form_a: assert property (key_cmd_wr && dev_wdata[30] |-> !dev_wdata[31])
    else $error("erase issued with set bit");
  key_range_a: assert property (key_cmd_wr |-> dev_wdata[7:0] < cap_r && dev_wdata[7:0] < MAX_KEYS)
    else $error("key index beyond capacity");
  gen_order_a: assert property (gen_load_s |=> gen_sts_wr && dev_wdata[31] && !dev_wdata[30])
    else $error("generic start out of order");
  gen_wait_a: assert property (gen_sts_wr |-> !gen_pend_r)
    else $error("generic command issued while active");
  slot_guard_a: assert property (gen_sts_wr && dev_wdata[3:0] == `GEN_TYPE_SLOTS |-> grp_seen_r)
    else $error("slot mask before group key");
  group_keep_a: assert property (key_cmd_wr && dev_wdata[30] && slots_r |-> dev_wdata[7:0] != grp_idx_r)
    else $error("group key erased while in use");
  read_quiet_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule
bind host_cmd_ctrl host_cmd_checker #(.MAX_KEYS(MAX_KEYS)) chk_u (.clock(clock), .rstn(rstn),
  .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
  .dev_rdata(dev_rdata), .queue_idle_req(queue_idle_req));

// ### dev_model.sv
// Behavioural model of the controlled device registers
`timescale 1ns/1ns
`include "host_cmd_defs.vh"
module dev_model #(
  parameter CAP = 4
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire        slow,
  input  wire [7:0]  dev_addr,
  input  wire [31:0] dev_wdata,
  input  wire        dev_wr,
  input  wire        dev_rd,
  output wire [31:0] dev_rdata
);
  localparam [7:0] CAP8 = CAP;
  reg [31:0]    sts_r, param_r, addr_r, kcmd_r, kid_r, stop_r;
  reg [127:0]   kv_r;
  reg [127:0]   key_r [0:CAP-1];
  reg [23:0]    key_identifier_r [0:CAP-1];
  reg [CAP-1:0] valid_r;
  reg           pend_r, wake_r;
  reg [4:0]     cnt_r;
  integer       gen_cnt;
  // Read data answers in the strobe cycle, which is where the sequencer samples it
  // capacity reported
  wire [31:0]   rdat_w = (dev_addr == `DEV_GEN_STS) ? sts_r :
                         (dev_addr == `DEV_KEY_CMD) ? kcmd_r :
                         (dev_addr == `DEV_STRUCT) ? {16'h0000, CAP8, 8'h00} : param_r;
  // Idle cycles show inverted data so stale values never pass
  assign dev_rdata = dev_rd ? rdat_w : ~rdat_w;
  // ----------------------------------------
  // Register file and delayed completion
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      {sts_r, kcmd_r, valid_r, pend_r, wake_r, cnt_r} <= '0;
      gen_cnt <= 0;
    end
    else
    begin
      if (cnt_r != 5'h00)
        cnt_r <= cnt_r - 5'h01;
      if (dev_wr)
        case (dev_addr)
          `DEV_GEN_STS:   {sts_r, gen_cnt, cnt_r} <= {dev_wdata, gen_cnt + 1, slow ? 5'h14 : 5'h02};
          `DEV_KEY_CMD:   {kcmd_r, cnt_r} <= {dev_wdata, slow ? 5'h14 : 5'h02};
          `DEV_GEN_PARAM: param_r <= dev_wdata;
          `DEV_GEN_ADDR:  addr_r <= dev_wdata;
          `DEV_KEY_ID:    kid_r <= dev_wdata;
          default:        kv_r[(dev_addr - 8'h14) * 8 +: 32] <= dev_wdata;
        endcase
      if (cnt_r == 5'h01)
      begin
        sts_r[31] <= 1'b0;
        if (sts_r[31] && sts_r[3:0] == `GEN_TYPE_STOP)
          if (!param_r[31])
            {pend_r, stop_r} <= {1'b1, param_r};
          else if (pend_r)
            pend_r <= 1'b0;
          else
            sts_r[30] <= 1'b1;
        if (sts_r[31] && sts_r[3:0] == `GEN_TYPE_WAKE)
          wake_r <= param_r[0];
        if (kcmd_r[31])
        begin
          key_r[kcmd_r[7:0]] <= kv_r;
          key_identifier_r[kcmd_r[7:0]] <= kid_r[23:0];
          valid_r[kcmd_r[7:0]] <= 1'b1;
          kcmd_r[31] <= 1'b0;
        end
        if (kcmd_r[30])
          {valid_r[kcmd_r[7:0]], kcmd_r[30]} <= 2'b00;
      end
    end
  end
endmodule

// ### host_generic_cmd_and_key_table_test.sv
// Self-checking bench for the host command sequencer
`timescale 1ns/1ns
`include "host_cmd_defs.vh"
module host_generic_cmd_and_key_table_test;
  reg         clock, rstn, sw_wr, sw_rd, slow;
  reg  [7:0]  sw_addr;
  reg  [31:0] sw_wdata, rd_v;
  wire [31:0] sw_rdata, dev_wdata, dev_rdata;
  wire [7:0]  dev_addr;
  wire        dev_wr, dev_rd, queue_idle_req;
  integer     miscompares, checks, cyc;
  host_cmd_ctrl #(.MAX_KEYS(8)) dut_u (.clock(clock), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .queue_idle_req(queue_idle_req));
  dev_model #(.CAP(4)) dev_u (.clock(clock), .rstn(rstn), .slow(slow), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clock);
    {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
    @(posedge clock);
    sw_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clock);
    {sw_addr, sw_rd} <= {a, 1'b1};
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 rd_v = sw_rdata;
  end
  endtask
  task chk(input string nm, input [127:0] exp, input [127:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value %0s expected %0h seen %0h", nm, exp, got);
    end
  end
  endtask
  // Start an operation, poll busy with a bound, then clear sticky flags
  task op(input [2:0] o);
    integer n;
  begin
    wr(`REG_CTRL, {29'h0, o});
    n = 0;
    rd(`REG_STATUS);
    while (rd_v[`ST_BUSY] !== 1'b0 && n < 300)
    begin
      rd(`REG_STATUS);
      n = n + 1;
    end
    chk("busy", 0, rd_v[`ST_BUSY]);
    wr(`REG_STATUS, 32'h0000_000E);
  end
  endtask
  task key(input [7:0] i, input g, input [31:0] s);
    reg [7:0] k;
  begin
    wr(`REG_KEY_ID, s);
    for (k = 8'h00; k < 8'h04; k = k + 8'h01)
      wr(`REG_KEY_VAL0 + (k << 2), s + k);
    wr(`REG_KEY_CMD, {23'h0, g, i});
    op(`OP_KEY_SET);
  end
  endtask
  task gen(input [3:0] t, input [31:0] p);
  begin
    wr(`REG_GEN_PARAM, p);
    wr(`REG_GEN_CMD, {28'h0, t});
    op(`OP_GENERIC);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // Free-running clock, 8 ns period
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard well above the expected run length
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn, sw_wr, sw_rd, slow, sw_addr, sw_wdata} = 0;
    {miscompares, checks, cyc} = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd(`REG_STATUS);
    chk("status", 0, rd_v);
    rd(8'hFC);
    chk("unmapped", 0, rd_v);
    wr(`REG_GEN_ADDR, 32'h0000_1000);
    gen(`GEN_TYPE_SLOTS, 0);
    chk("early mask", 4'hA, rd_v[3:0]);
    chk("mask count", 0, dev_u.gen_cnt);
    key(0, 1'b1, 32'h00A1_B2C3);
    chk("group key", {32'h00A1_B2C6, 32'h00A1_B2C5, 32'h00A1_B2C4, 32'h00A1_B2C3}, dev_u.key_r[0]);
    chk("group ok", 5'h12, rd_v[4:0]);
    key(1, 1'b0, 32'h0000_0011);
    key(1, 1'b0, 32'h0055_0022);
    chk("overwrite", {32'h0055_0025, 32'h0055_0024, 32'h0055_0023, 32'h0055_0022}, dev_u.key_r[1]);
    chk("key id", 24'h55_0022, dev_u.key_identifier_r[1]);
    key(4, 1'b0, 32'h0000_0033);
    chk("at capacity", 4'hA, rd_v[3:0]);
    key(9, 1'b0, 32'h0000_0044);
    chk("above max", 4'hA, rd_v[3:0]);
    gen(`GEN_TYPE_SLOTS, 0);
    chk("mask done", 3'h6, rd_v[5:3]);
    chk("mask ptr", 32'h0000_1000, dev_u.addr_r);
    rd(`REG_GEN_ADDR);
    chk("ptr back", 32'h0000_1000, rd_v);
    slow <= 1'b1;
    gen(`GEN_TYPE_STOP, 32'h0000_1234);
    chk("stop time", 33'h1_0000_1234, {dev_u.pend_r, dev_u.stop_r});
    gen(`GEN_TYPE_STOP, 32'h8000_0000);
    chk("cancel", 5'h02, {dev_u.pend_r, rd_v[3:0]});
    gen(`GEN_TYPE_STOP, 32'h8000_0000);
    chk("bad cancel", 4'h6, rd_v[3:0]);
    slow <= 1'b0;
    gen(`GEN_TYPE_WAKE, 32'h0000_0001);
    chk("wake on", 2'h3, {dev_u.wake_r, rd_v[`ST_WAKE_POLL]});
    gen(`GEN_TYPE_WAKE, 32'h0000_0000);
    chk("wake off", 2'h0, {dev_u.wake_r, rd_v[`ST_WAKE_POLL]});
    wr(`REG_KEY_CMD, 32'h0000_0000);
    op(`OP_KEY_ERASE);
    chk("erase group", 5'h0A, {dev_u.valid_r[0] ^ 1'b1, rd_v[3:0]});
    wr(`REG_KEY_CMD, 32'h0000_0001);
    op(`OP_KEY_ERASE);
    chk("erase", 5'h02, {dev_u.valid_r[1], rd_v[3:0]});
    op(`OP_KEY_ERASE);
    chk("erase empty", 4'hA, rd_v[3:0]);
    op(`OP_HANDSHAKE);
    chk("idle queues", 1, queue_idle_req);
    rd(`REG_DEV_INFO);
    chk("insecure info", 32'h0000_0001, rd_v);
    key(2, 1'b0, 32'h0000_0066);
    chk("pairwise", 2'h1, {queue_idle_req, dev_u.valid_r[2]});
    rd(`REG_DEV_INFO);
    chk("secure info", 32'h0000_0102, rd_v);
    slow <= 1'b1;
    wr(`REG_CTRL, {29'h0, `OP_GENERIC});
    op(`OP_GENERIC);
    chk("one start", 7, dev_u.gen_cnt);
    wrap_up;
  end
endmodule
